// ===== rtl/ldwp_write_port.sv
// Write-side host port of an 8-digit LED display driver
// Notes on behaviour
// [RL1] The byte on the input lines is taken at the rising edge of the write strobe.
// [RL2] Select high loads the control register and select low loads display memory.
// [RL3] In a data write lines 0 to 7 are data bits 1 to 8, bit 8 being the point segment.
// [RL4] Control line 6 high picks hexadecimal and low picks Code B translation.
// [RL5] Control line 5 high turns translation off and low turns it on.
// [RL6] Control line 7 high announces a sequential burst and low announces none.
// [RL7] Control line 4 high is normal operation and low stops and blanks the display.
// [RL8] With no burst, control lines 0 to 2 give the digit address, line 0 the LSB.
// [RL9] Control line 3 picks bank A when high and bank B when low, only while decoding.
// [RL10] After a burst announcement eight data writes fill digits one to eight in order.
// [RL11] After a single-digit control word the next data write goes only to that digit.
`timescale 1ns/100ps
module ldwp_write_port
  import ldwp_pkg::*;
#(
  parameter int DIGITS = LDWP_DIGITS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] input_lines,
  input wire logic target_select,
  input wire logic write_strobe,
  output ldwp_ctrl_t display_control,
  output logic font_select,
  output logic decode_enable,
  output logic display_on,
  output logic bank_a_active,
  output logic [8*LDWP_DIGITS-1:0] bank_a_data,
  output logic [8*LDWP_DIGITS-1:0] bank_b_data,
  output logic [LDWP_DIGITS-1:0] point_segment,
  output logic data_written,
  output logic [2:0] written_digit
);
  logic [9:0] pins_raw;
  logic [9:0] pins_sync;
  logic [7:0] data_s;
  logic sel_s;
  logic strobe_s;
  logic strobe_d_reg;
  logic strobe_rise;
  ldwp_ctrl_t ctrl_reg;
  ldwp_state_t state_reg;
  logic [2:0] ptr_reg;
  logic [7:0] mem_a_reg [LDWP_DIGITS];
  logic [7:0] mem_b_reg [LDWP_DIGITS];
  logic wr_en;
  logic [2:0] wr_idx;
  logic wr_bank_a;
  logic done_reg;
  logic [2:0] done_idx_reg;

  assign pins_raw = {write_strobe, target_select, input_lines};

  // Idle levels: strobe high, select low, data zero
  ldwp_pin_sync #(.WIDTH(10), .RESET_VAL({2'b10, 8'h00})) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_in(pins_raw),
    .pin_out(pins_sync)
  );

  assign data_s = pins_sync[7:0];
  assign sel_s = pins_sync[8];
  assign strobe_s = pins_sync[9];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strobe_d_reg <= 1'b1;
    end else begin
      strobe_d_reg <= strobe_s;
    end
  end

  // Data and select are stable around the strobe edge, so sample at the edge
  assign strobe_rise = strobe_s && !strobe_d_reg; // [RL1]

  // Control word capture
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= ldwp_ctrl_t'(LDWP_CTRL_RESET);
    end else if (strobe_rise && sel_s) begin // [RL2]
      ctrl_reg.seq_follows <= data_s[LDWP_SEQ_BIT]; // [RL6]
      ctrl_reg.font_select <= data_s[LDWP_FONT_BIT]; // [RL4]
      ctrl_reg.no_decode <= data_s[LDWP_RAW_BIT]; // [RL5]
      ctrl_reg.run <= data_s[LDWP_RUN_BIT]; // [RL7]
      ctrl_reg.bank_a <= data_s[LDWP_BANK_BIT]; // [RL9]
      ctrl_reg.digit_addr <= data_s[LDWP_ADDR_LSB +: LDWP_ADDR_W]; // [RL8]
    end
  end

  // Update sequencing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= LDWP_ST_IDLE;
      ptr_reg <= 3'h0;
    end else if (strobe_rise) begin
      if (sel_s) begin
        ptr_reg <= 3'h0;
        if (data_s[LDWP_SEQ_BIT]) begin
          state_reg <= LDWP_ST_BURST; // [RL10]
        end else begin
          state_reg <= LDWP_ST_SINGLE; // [RL11]
        end
      end else begin
        case (state_reg)
          LDWP_ST_BURST: begin
            ptr_reg <= ptr_reg + 3'h1; // [RL10]
            if (ptr_reg == 3'(DIGITS - 1)) begin
              state_reg <= LDWP_ST_IDLE;
            end
          end
          LDWP_ST_SINGLE: state_reg <= LDWP_ST_IDLE; // [RL11]
          LDWP_ST_IDLE: state_reg <= LDWP_ST_IDLE;
          default: state_reg <= LDWP_ST_IDLE;
        endcase
      end
    end
  end

  // Data writes outside a sequence are ignored
  always_comb begin
    wr_en = strobe_rise && !sel_s && (state_reg != LDWP_ST_IDLE); // [RL2]
    wr_idx = (state_reg == LDWP_ST_BURST) ? ptr_reg : ctrl_reg.digit_addr; // [RL8]
    // Bank choice applies only while translation is on; no-decode uses bank A
    wr_bank_a = ctrl_reg.bank_a || ctrl_reg.no_decode; // [RL9]
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < LDWP_DIGITS; i++) begin
        mem_a_reg[i] <= LDWP_DATA_RESET;
        mem_b_reg[i] <= LDWP_DATA_RESET;
      end
    end else if (wr_en) begin
      if (wr_bank_a) begin
        mem_a_reg[wr_idx] <= data_s; // [RL3]
      end else begin
        mem_b_reg[wr_idx] <= data_s; // [RL3]
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done_reg <= 1'b0;
      done_idx_reg <= 3'h0;
    end else begin
      done_reg <= wr_en;
      if (wr_en) begin
        done_idx_reg <= wr_idx;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < LDWP_DIGITS; i++) begin
      bank_a_data[8*i +: 8] = mem_a_reg[i];
      bank_b_data[8*i +: 8] = mem_b_reg[i];
      point_segment[i] = bank_a_active ? mem_a_reg[i][LDWP_POINT_BIT]
                                       : mem_b_reg[i][LDWP_POINT_BIT]; // [RL3]
    end
  end

  assign display_control = ctrl_reg;
  assign font_select = ctrl_reg.font_select; // [RL4]
  assign decode_enable = !ctrl_reg.no_decode; // [RL5]
  assign display_on = ctrl_reg.run; // [RL7]
  assign bank_a_active = ctrl_reg.bank_a || ctrl_reg.no_decode; // [RL9]
  assign data_written = done_reg;
  assign written_digit = done_idx_reg;

  property p_ctrl_capture;
    @(posedge core_clk) disable iff (!resetn)
      (strobe_rise && sel_s) |=> (ctrl_reg == $past(data_s));
  endproperty
  a_ctrl_capture: assert property (p_ctrl_capture) // [RL2]
    else $error("Control word not captured on strobe");

  property p_no_ctrl_on_data;
    @(posedge core_clk) disable iff (!resetn)
      !(strobe_rise && sel_s) |=> $stable(ctrl_reg);
  endproperty
  a_no_ctrl_on_data: assert property (p_no_ctrl_on_data) // [RL1]
    else $error("Control word changed without control strobe");

  property p_burst_start;
    @(posedge core_clk) disable iff (!resetn)
      (strobe_rise && sel_s && data_s[LDWP_SEQ_BIT]) |=>
        (state_reg == LDWP_ST_BURST && ptr_reg == 3'h0);
  endproperty
  a_burst_start: assert property (p_burst_start) // [RL6]
    else $error("Burst did not start at digit one");

  property p_burst_step;
    @(posedge core_clk) disable iff (!resetn)
      (wr_en && state_reg == LDWP_ST_BURST) |-> ##2 (written_digit == $past(ptr_reg, 2));
  endproperty
  a_burst_step: assert property (p_burst_step) // [RL10]
    else $error("Burst wrote wrong digit");

  property p_burst_end;
    @(posedge core_clk) disable iff (!resetn)
      (wr_en && state_reg == LDWP_ST_BURST && ptr_reg == 3'h7) |=>
        (state_reg == LDWP_ST_IDLE);
  endproperty
  a_burst_end: assert property (p_burst_end) // [RL10]
    else $error("Burst did not end after eight digits");

  property p_single_once;
    @(posedge core_clk) disable iff (!resetn)
      (wr_en && state_reg == LDWP_ST_SINGLE) |=> (state_reg == LDWP_ST_IDLE);
  endproperty
  a_single_once: assert property (p_single_once) // [RL11]
    else $error("Single-digit update accepted more than one write");

  property p_single_addr;
    @(posedge core_clk) disable iff (!resetn)
      (wr_en && state_reg == LDWP_ST_SINGLE) |=> (written_digit == ctrl_reg.digit_addr);
  endproperty
  a_single_addr: assert property (p_single_addr) // [RL8]
    else $error("Single-digit write went to wrong digit");

  property p_data_store;
    @(posedge core_clk) disable iff (!resetn)
      (wr_en && wr_bank_a) |=> (mem_a_reg[$past(wr_idx)] == $past(data_s));
  endproperty
  a_data_store: assert property (p_data_store) // [RL3]
    else $error("Display data not stored in bank A");

  property p_flags;
    @(posedge core_clk) disable iff (!resetn)
      (strobe_rise && sel_s) |=> (font_select == $past(data_s[LDWP_FONT_BIT]))
        && (decode_enable == !$past(data_s[LDWP_RAW_BIT]))
        && (display_on == $past(data_s[LDWP_RUN_BIT]));
  endproperty
  a_flags: assert property (p_flags) // [RL4]
    else $error("Mode outputs disagree with control word");

  property p_bank_b;
    @(posedge core_clk) disable iff (!resetn)
      (wr_en && !ctrl_reg.bank_a && ctrl_reg.no_decode) |=> $stable(bank_b_data);
  endproperty
  a_bank_b: assert property (p_bank_b) // [RL9]
    else $error("Bank B written in no-decode mode");
endmodule // ldwp_write_port

// ===== rtl/ldwp_pkg.sv
// Package of constants and types for the LED display write port
package ldwp_pkg;
  localparam int LDWP_DIGITS = 8;
  localparam int LDWP_ADDR_W = 3;
  // Control word field positions and the data byte point bit
  localparam int LDWP_ADDR_LSB = 0;
  localparam int LDWP_BANK_BIT = 3;
  localparam int LDWP_RUN_BIT = 4;
  localparam int LDWP_RAW_BIT = 5;
  localparam int LDWP_FONT_BIT = 6;
  localparam int LDWP_SEQ_BIT = 7;
  localparam int LDWP_POINT_BIT = 7;
  // Reset value of the control word: normal operation, decode, bank A, no burst
  localparam logic [7:0] LDWP_CTRL_RESET = 8'h18;
  localparam logic [7:0] LDWP_DATA_RESET = 8'h00;

  typedef struct packed {
    logic seq_follows;
    logic font_select;
    logic no_decode;
    logic run;
    logic bank_a;
    logic [2:0] digit_addr;
  } ldwp_ctrl_t;

  typedef enum logic [1:0] {
    LDWP_ST_IDLE = 2'b00,
    LDWP_ST_SINGLE = 2'b01,
    LDWP_ST_BURST = 2'b10
  } ldwp_state_t;
endpackage

// ===== rtl/ldwp_pin_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module ldwp_pin_sync
  import ldwp_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;

  // Stages start at the idle pin levels so no false edge follows reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Per bit, a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_reg <= RESET_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          out_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign pin_out = out_reg;
endmodule // ldwp_pin_sync

// ===== test/ldwp_host_model.sv
// Host model that strobes control words and display bytes into the port
`timescale 1ns/100ps
module ldwp_host_model (
  input wire logic core_clk,
  output logic [7:0] input_lines,
  output logic target_select,
  output logic write_strobe
);
  initial begin
    input_lines = 8'h00;
    target_select = 1'b0;
    write_strobe = 1'b1;
  end

  // One write: select and byte held well around the strobe rise
  task automatic put(input logic sel, input logic [7:0] d);
    @(posedge core_clk);
    target_select <= sel;
    input_lines <= d;
    write_strobe <= 1'b0;
    repeat (7) @(posedge core_clk);
    write_strobe <= 1'b1;
    repeat (8) @(posedge core_clk);
    // Released lines show the inverse so stale data never looks valid
    input_lines <= ~d;
  endtask
endmodule // ldwp_host_model

// ===== test/test_led_display_write_port.sv
// Self-checking bench for the LED display write port
`timescale 1ns/100ps
module test_led_display_write_port;
  import ldwp_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] input_lines;
  logic target_select;
  logic write_strobe;
  ldwp_ctrl_t display_control;
  logic font_select;
  logic decode_enable;
  logic display_on;
  logic bank_a_active;
  logic data_written;
  logic [63:0] bank_a_data;
  logic [63:0] bank_b_data;
  logic [63:0] exp_a = 64'h0;
  logic [63:0] exp_b = 64'h0;
  logic [7:0] point_segment;
  logic [2:0] written_digit;
  int fail_count = 0;
  int samples_checked = 0;
  int pulses = 0;

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (data_written === 1'b1) begin
      pulses++;
    end
  end

  ldwp_host_model u_ldwp_host_model (
    .core_clk(core_clk),
    .input_lines(input_lines),
    .target_select(target_select),
    .write_strobe(write_strobe)
  );

  ldwp_write_port u_ldwp_write_port (
    .core_clk(core_clk),
    .resetn(resetn),
    .input_lines(input_lines),
    .target_select(target_select),
    .write_strobe(write_strobe),
    .display_control(display_control),
    .font_select(font_select),
    .decode_enable(decode_enable),
    .display_on(display_on),
    .bank_a_active(bank_a_active),
    .bank_a_data(bank_a_data),
    .bank_b_data(bank_b_data),
    .point_segment(point_segment),
    .data_written(data_written),
    .written_digit(written_digit)
  );

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Reset values, then a data write with no control word is dropped
  task automatic t_reset();
    check("ctrl", display_control, LDWP_CTRL_RESET);
    u_ldwp_host_model.put(1'b0, 8'h5a);
    check("mem_a", bank_a_data, exp_a);
    check("mem_b", bank_b_data, exp_b);
    check("pulses", pulses, 0);
    $display("test reset done");
  endtask

  // Every control field except the burst flag (bit 7, always low here), both levels
  task automatic t_ctrl();
    logic [7:0] w[4] = '{8'h40, 8'h3d, 8'h27, 8'h18};
    foreach (w[i]) begin
      u_ldwp_host_model.put(1'b1, w[i]);
      check("ctrl", display_control, w[i]);
      check("font", font_select, w[i][6]);
      check("decode", decode_enable, !w[i][5]);
      check("run", display_on, w[i][4]);
      check("bank", bank_a_active, w[i][3] | w[i][5]);
    end
    $display("test control done");
  endtask

  // Burst of eight into bank A, a ninth write is dropped
  task automatic t_burst();
    int base;
    logic [7:0] d;
    logic [7:0] p;
    u_ldwp_host_model.put(1'b1, 8'h98);
    base = pulses;
    for (int i = 0; i < 8; i++) begin
      d = 8'h1c + 8'(8'h25 * i);
      exp_a[8*i+:8] = d;
      p[i] = d[7];
      u_ldwp_host_model.put(1'b0, d);
    end
    u_ldwp_host_model.put(1'b0, 8'hff);
    check("burst_a", bank_a_data, exp_a);
    check("burst_b", bank_b_data, exp_b);
    check("point", point_segment, p);
    check("count", pulses - base, 8);
    check("last", written_digit, 3'h7);
    $display("test burst done");
  endtask

  // Single digit 5 of bank B, a second write is dropped
  task automatic t_single();
    u_ldwp_host_model.put(1'b1, 8'h15);
    u_ldwp_host_model.put(1'b0, 8'hc3);
    u_ldwp_host_model.put(1'b0, 8'h77);
    exp_b[47:40] = 8'hc3;
    check("single_b", bank_b_data, exp_b);
    check("single_a", bank_a_data, exp_a);
    check("digit", written_digit, 3'h5);
    check("point", point_segment, 8'h20);
    $display("test single done");
  endtask

  // No-decode with bank bit low still writes digit 2 of bank A
  task automatic t_raw();
    u_ldwp_host_model.put(1'b1, 8'h22);
    u_ldwp_host_model.put(1'b0, 8'h81);
    exp_a[23:16] = 8'h81;
    check("raw_a", bank_a_data, exp_a);
    check("raw_b", bank_b_data, exp_b);
    check("raw_digit", written_digit, 3'h2);
    check("raw_point", point_segment, 8'h7c);
    $display("test raw done");
  endtask

  initial begin
    repeat (4000) @(posedge core_clk);
    fail_count++;
    results();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_reset();
    t_ctrl();
    t_burst();
    t_single();
    t_raw();
    results();
  end
endmodule // test_led_display_write_port
